/* File: rtl/psr_pkg.sv */
// shared constants and types of the pipelined burst sram control stage
package psr_pkg;
    localparam int ADDR_W  = 20;
    localparam int LANES   = 4;
    localparam int BYTE_W  = 8;
    localparam int LANE_W  = BYTE_W + 1;
    localparam int BURST_W = 2;
    localparam int PIPE_RD = 2;
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
    localparam logic                STRAP_RESET = 1'b1;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } psr_op_e;
endpackage

/* File: rtl/psr_mem_if.sv */
// carrier between the control stage and the lane storage
`timescale 1ns/1ps
`default_nettype none
interface psr_mem_if #(
    parameter int ADDR_W = psr_pkg::ADDR_W
);
    logic [ADDR_W-1:0]                               rd_addr;
    logic [psr_pkg::LANES*psr_pkg::LANE_W-1:0]       rd_data;
    logic                                            wr_en;
    logic [ADDR_W-1:0]                               wr_addr;
    logic [psr_pkg::LANES-1:0]                       wr_lane;
    logic [psr_pkg::LANES*psr_pkg::LANE_W-1:0]       wr_data;

    modport ctrl  (output rd_addr, input rd_data, output wr_en, output wr_addr,
                   output wr_lane, output wr_data);
    modport array (input rd_addr, output rd_data, input wr_en, input wr_addr,
                   input wr_lane, input wr_data);
endinterface
`default_nettype wire

/* File: rtl/psr_burst.sv */
// two-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module psr_burst (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        load,
    input  wire logic                        advance,
    input  wire logic [psr_pkg::BURST_W-1:0] base_lo,
    input  wire logic                        interleave,
    output logic      [psr_pkg::BURST_W-1:0] next_lo
);
    logic [psr_pkg::BURST_W-1:0] base_q;
    logic [psr_pkg::BURST_W-1:0] base_d;
    logic [psr_pkg::BURST_W-1:0] cnt_q;
    logic [psr_pkg::BURST_W-1:0] cnt_d;

    always_comb begin
        base_d = base_q;
        cnt_d  = cnt_q;
        if (load) begin
            base_d = base_lo;
            cnt_d  = psr_pkg::BURST_START;
        end else if (advance) begin
            cnt_d = cnt_q + psr_pkg::BURST_STEP;
        end
        // counter wraps inside the 4-word block in both orders
        if (interleave) begin
            next_lo = base_d ^ cnt_d;
        end else begin
            next_lo = base_d + cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            base_q <= psr_pkg::BURST_START;
            cnt_q  <= psr_pkg::BURST_START;
        end else begin
            base_q <= base_d;
            cnt_q  <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/psr_array.sv */
// lane storage: one 9-bit word per lane and address, written lane by lane
`timescale 1ns/1ps
`default_nettype none
module psr_array #(
    parameter int ADDR_W = psr_pkg::ADDR_W
) (
    input  wire logic clk,
    psr_mem_if.array  mem
);
    localparam int DEPTH = 1 << ADDR_W;

    for (genvar i = 0; i < psr_pkg::LANES; i++) begin : g_lane
        logic [psr_pkg::LANE_W-1:0] store [DEPTH];

        // no reset: contents are undefined until written, as in a real array
        always_ff @(posedge clk) begin
            if (mem.wr_en && mem.wr_lane[i]) begin
                store[mem.wr_addr] <=
                    mem.wr_data[i*psr_pkg::LANE_W +: psr_pkg::LANE_W];
            end
        end

        assign mem.rd_data[i*psr_pkg::LANE_W +: psr_pkg::LANE_W] = store[mem.rd_addr];
    end
endmodule
`default_nettype wire

/* File: rtl/psr_sram_ctrl.sv */
// synchronous control input stage and data pipeline of a burst sram
// Notes on behaviour
// - the address, burst bits included, is taken on a qualified rising edge and picks one word.
// - lane selects are sampled on the edge, active low, and act only in a write: a load with write enable low and its advances.
// - each lane select gates its own data byte and parity bit, the four lanes independently.
// - write enable low on a qualified loading edge starts a write, high means a read.
// - advance/load high on a qualified edge steps the burst counter instead of loading.
// - advance/load low loads the presented address as the start of a new access.
// - every synchronous input is captured only on edges where the clock qualifier is low.
// - the first select is active low and all three selects must be true to choose the device.
// - the second select is active high and low on it deselects the device.
// - the third select is active low and high on it deselects the device.
// - clock qualifier high freezes all state and stretches the cycle without deselecting.
// - outputs float on write data, on the first cycle out of deselect and while deselected.
// - the strap picks interleaved order when high, linear when low, and is held during use.
`timescale 1ns/1ps
`default_nettype none
module psr_sram_ctrl #(
    parameter int ADDR_W = psr_pkg::ADDR_W
) (
    input  wire logic                                     clk,
    input  wire logic                                     sys_rst,
    input  wire logic [ADDR_W-1:psr_pkg::BURST_W]         addr_upper,
    input  wire logic                                     burst_addr_bit_low,
    input  wire logic                                     burst_addr_bit_high,
    input  wire logic                                     lane_a_write_sel_n,
    input  wire logic                                     lane_b_write_sel_n,
    input  wire logic                                     lane_c_write_sel_n,
    input  wire logic                                     lane_d_write_sel_n,
    input  wire logic                                     write_en_n,
    input  wire logic                                     advance_or_load,
    input  wire logic                                     clock_qualify_n,
    input  wire logic                                     select_first_n,
    input  wire logic                                     select_second,
    input  wire logic                                     select_third_n,
    input  wire logic                                     output_en_n,
    input  wire logic                                     burst_order_strap,
    input  wire logic [psr_pkg::LANES*psr_pkg::BYTE_W-1:0] data_lanes_in,
    output logic      [psr_pkg::LANES*psr_pkg::BYTE_W-1:0] data_lanes_out,
    output logic      [psr_pkg::LANES-1:0]                 data_lanes_oe,
    input  wire logic [psr_pkg::LANES-1:0]                 parity_lanes_in,
    output logic      [psr_pkg::LANES-1:0]                 parity_lanes_out,
    output logic      [psr_pkg::LANES-1:0]                 parity_lanes_oe
);
    localparam int LW = psr_pkg::LANE_W;
    localparam int BW = psr_pkg::BYTE_W;
    localparam int NL = psr_pkg::LANES;

    typedef struct packed {
        psr_pkg::psr_op_e  op;
        logic [ADDR_W-1:0] addr;
        logic [NL-1:0]     lanes;
    } psr_cmd_s;

    localparam psr_cmd_s CMD_IDLE = '{op: psr_pkg::OP_IDLE, addr: '0, lanes: '0};

    psr_mem_if #(.ADDR_W(ADDR_W)) mem ();

    psr_array #(.ADDR_W(ADDR_W)) u_array (
        .clk (clk),
        .mem (mem)
    );

    logic                               run;
    logic                               selected;
    logic                               load;
    logic [NL-1:0]                      lane_sel_n;
    logic [psr_pkg::BURST_W-1:0]        burst_next;
    logic                               burst_load;
    logic                               burst_adv;
    logic [NL*LW-1:0]                   rd_merged;
    psr_pkg::psr_op_e                   op_now;

    psr_cmd_s                           cmd1_q;
    psr_cmd_s                           cmd1_d;
    psr_cmd_s                           cmd2_q;
    psr_cmd_s                           cmd2_d;
    logic [ADDR_W-1:psr_pkg::BURST_W]   upper_q;
    logic [ADDR_W-1:psr_pkg::BURST_W]   upper_d;
    psr_pkg::psr_op_e                   op_last_q;
    psr_pkg::psr_op_e                   op_last_d;
    logic [NL*LW-1:0]                   dout_q;
    logic [NL*LW-1:0]                   dout_d;
    logic                               mode_q;
    logic                               mode_d;

    assign run        = ~clock_qualify_n;
    assign selected   = ~select_first_n & select_second & ~select_third_n;
    assign load       = ~advance_or_load;
    assign lane_sel_n = {lane_d_write_sel_n, lane_c_write_sel_n,
                         lane_b_write_sel_n, lane_a_write_sel_n};

    psr_burst u_burst (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .load       (burst_load),
        .advance    (burst_adv),
        .base_lo    ({burst_addr_bit_high, burst_addr_bit_low}),
        .interleave (mode_q),
        .next_lo    (burst_next)
    );

    // write port: stage two holds the write whose data arrives now
    assign mem.wr_en   = run && (cmd2_q.op == psr_pkg::OP_WRITE);
    assign mem.wr_addr = cmd2_q.addr;
    assign mem.wr_lane = cmd2_q.lanes;
    assign mem.rd_addr = cmd1_q.addr;

    for (genvar i = 0; i < NL; i++) begin : g_lane
        logic fwd;
        assign mem.wr_data[i*LW +: LW] = {parity_lanes_in[i],
                                          data_lanes_in[i*BW +: BW]};
        // a read right behind a write to the same word would see stale storage
        assign fwd = mem.wr_en && cmd2_q.lanes[i] && (cmd2_q.addr == cmd1_q.addr);
        assign rd_merged[i*LW +: LW] = fwd ? mem.wr_data[i*LW +: LW]
                                           : mem.rd_data[i*LW +: LW];
        assign data_lanes_out[i*BW +: BW] = dout_q[i*LW +: BW];
        assign parity_lanes_out[i]        = dout_q[i*LW + BW];
        // drive only for a read in its data cycle: never on write data,
        // never while deselected, never on the first cycle out of deselect
        assign data_lanes_oe[i]   = (cmd2_q.op == psr_pkg::OP_READ) && ~output_en_n;
        assign parity_lanes_oe[i] = (cmd2_q.op == psr_pkg::OP_READ) && ~output_en_n;
    end

    always_comb begin
        cmd1_d     = cmd1_q;
        cmd2_d     = cmd2_q;
        upper_d    = upper_q;
        op_last_d  = op_last_q;
        dout_d     = dout_q;
        burst_load = 1'b0;
        burst_adv  = 1'b0;
        op_now     = psr_pkg::OP_IDLE;
        // strap is caught while reset is held and then kept
        mode_d     = sys_rst ? burst_order_strap : mode_q;
        // a stalled edge leaves every stage as it is
        if (run) begin
            cmd2_d = cmd1_q;
            if (load) begin
                burst_load = 1'b1;
                upper_d    = addr_upper;
                if (!selected) begin
                    op_now = psr_pkg::OP_IDLE;
                end else if (!write_en_n) begin
                    op_now = psr_pkg::OP_WRITE;
                end else begin
                    op_now = psr_pkg::OP_READ;
                end
                op_last_d = op_now;
            end else begin
                // advance continues the loaded access; after deselect it stays idle
                burst_adv = 1'b1;
                op_now    = op_last_q;
            end
            cmd1_d.op   = op_now;
            cmd1_d.addr = {(load ? addr_upper : upper_q), burst_next};
            cmd1_d.lanes = (op_now == psr_pkg::OP_WRITE) ? ~lane_sel_n : '0;
            if (cmd1_q.op == psr_pkg::OP_READ) begin
                dout_d = rd_merged;
            end
        end
    end

    always_ff @(posedge clk) begin
        mode_q <= mode_d;
        if (sys_rst) begin
            cmd1_q    <= CMD_IDLE;
            cmd2_q    <= CMD_IDLE;
            upper_q   <= '0;
            op_last_q <= psr_pkg::OP_IDLE;
            dout_q    <= '0;
        end else begin
            cmd1_q    <= cmd1_d;
            cmd2_q    <= cmd2_d;
            upper_q   <= upper_d;
            op_last_q <= op_last_d;
            dout_q    <= dout_d;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/psr_sram_ctrl_sva.sv */
// pin level assertions of the burst sram control stage
`timescale 1ns/1ps
`default_nettype none
module psr_sram_ctrl_sva (
    input wire logic                                     clk,
    input wire logic                                     sys_rst,
    input wire logic                                     write_en_n,
    input wire logic                                     advance_or_load,
    input wire logic                                     clock_qualify_n,
    input wire logic                                     select_first_n,
    input wire logic                                     select_second,
    input wire logic                                     select_third_n,
    input wire logic                                     output_en_n,
    input wire logic [psr_pkg::LANES*psr_pkg::BYTE_W-1:0] data_lanes_out,
    input wire logic [psr_pkg::LANES-1:0]                 data_lanes_oe,
    input wire logic [psr_pkg::LANES-1:0]                 parity_lanes_oe
);
    logic sel_ok;
    assign sel_ok = !select_first_n && select_second && !select_third_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence ld_s(x);
        !clock_qualify_n && !advance_or_load && x;
    endsequence
    // prior edge must be a selected load, so the first cycle after deselect is excluded
    a_read_drives: assert property (
        ld_s(sel_ok) ##1 ld_s(sel_ok && write_en_n) ##1 !clock_qualify_n ##1 !output_en_n
        |-> data_lanes_oe == 4'hF)
        else $error("read data not driven");
    a_write_floats: assert property (
        ld_s(sel_ok && !write_en_n) ##1 !clock_qualify_n
        |=> data_lanes_oe == 4'h0 && parity_lanes_oe == 4'h0)
        else $error("bus driven during write data");
    a_desel_first: assert property (
        ld_s(select_first_n) ##1 !clock_qualify_n |=> data_lanes_oe == 4'h0)
        else $error("first select ignored");
    a_desel_second: assert property (
        ld_s(!select_second) ##1 !clock_qualify_n |=> data_lanes_oe == 4'h0)
        else $error("second select ignored");
    a_desel_third: assert property (
        ld_s(select_third_n) ##1 !clock_qualify_n |=> data_lanes_oe == 4'h0)
        else $error("third select ignored");
    a_stall_freeze: assert property (
        clock_qualify_n |=> $stable(data_lanes_out))
        else $error("output moved on stalled edge");
    a_oe_masked: assert property (
        output_en_n |-> data_lanes_oe == 4'h0 && parity_lanes_oe == 4'h0)
        else $error("drive without output enable");
    a_oe_lanes_same: assert property (
        data_lanes_oe == parity_lanes_oe && (data_lanes_oe == 4'h0 || data_lanes_oe == 4'hF))
        else $error("lane enables differ");
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> data_lanes_out == '0 && data_lanes_oe == 4'h0)
        else $error("outputs active after reset");
endmodule
bind psr_sram_ctrl psr_sram_ctrl_sva u_sva (.clk, .sys_rst, .write_en_n, .advance_or_load,
    .clock_qualify_n, .select_first_n, .select_second, .select_third_n, .output_en_n,
    .data_lanes_out, .data_lanes_oe, .parity_lanes_oe);
`default_nettype wire

/* File: testbench/psr_host.sv */
// host controller model driving the burst sram pins, write data two edges late
`timescale 1ns/1ps
`default_nettype none
module psr_host #(parameter int AW = 6) (
    input  wire logic          clk,
    input  wire logic          rq_adv,
    input  wire logic          rq_we_n,
    input  wire logic [2:0]    rq_sel,
    input  wire logic [3:0]    rq_ln,
    input  wire logic [AW-1:0] rq_adr,
    input  wire logic [35:0]   rq_wd,
    input  wire logic          rq_wv,
    input  wire logic          rq_stall,
    output logic      [AW-1:2] a_up,
    output logic      [1:0]    a_lo,
    output logic      [3:0]    ln_n,
    output logic               we_n,
    output logic               adv,
    output logic               qn,
    output logic      [2:0]    sel,
    output logic      [35:0]   wd
);
    logic [36:0] s1_q, s2_q;
    // pipe moves only on qualified edges, matching the device's stretched cycle
    always @(posedge clk) if (!rq_stall) begin
        s1_q <= {rq_wv, rq_wd};
        s2_q <= s1_q;
    end
    assign {a_up, a_lo} = rq_adr;
    assign ln_n = rq_ln;
    assign we_n = rq_we_n;
    assign adv = rq_adv;
    assign qn = rq_stall;
    assign sel = {~rq_sel[2], rq_sel[1], ~rq_sel[0]};
    // outside write data slots the pins show the inverse, never a stale copy
    assign wd = s2_q[36] ? s2_q[35:0] : ~s2_q[35:0];
endmodule
`default_nettype wire

/* File: testbench/psr_sram_ctrl_bench.sv */
// self-checking bench of the burst sram control stage
`timescale 1ns/1ps
`default_nettype none
module psr_sram_ctrl_bench;
    localparam int AW = 6;
    logic clk = 1'b0, sys_rst = 1'b1, oen = 1'b0, strap = 1'b1;
    logic rq_adv = 1'b0, rq_we_n = 1'b1, rq_wv = 1'b0, rq_stall = 1'b0;
    logic [2:0] rq_sel = 3'h7, h_sel;
    logic [3:0] rq_ln = 4'hF, h_ln, doe, pout, poe;
    logic [AW-1:0] rq_adr = '0;
    logic [35:0] rq_wd = '0, h_wd;
    logic [AW-1:2] h_up;
    logic [1:0] h_lo;
    logic h_we, h_adv, h_qn;
    logic [31:0] dout;
    int error_cnt = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    psr_host #(.AW(AW)) i_host (.clk(clk), .rq_adv(rq_adv), .rq_we_n(rq_we_n), .rq_sel(rq_sel),
        .rq_ln(rq_ln), .rq_adr(rq_adr), .rq_wd(rq_wd), .rq_wv(rq_wv), .rq_stall(rq_stall),
        .a_up(h_up), .a_lo(h_lo), .ln_n(h_ln), .we_n(h_we), .adv(h_adv), .qn(h_qn),
        .sel(h_sel), .wd(h_wd));
    psr_sram_ctrl #(.ADDR_W(AW)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .addr_upper(h_up), .burst_addr_bit_low(h_lo[0]),
        .burst_addr_bit_high(h_lo[1]), .lane_a_write_sel_n(h_ln[0]),
        .lane_b_write_sel_n(h_ln[1]), .lane_c_write_sel_n(h_ln[2]),
        .lane_d_write_sel_n(h_ln[3]), .write_en_n(h_we), .advance_or_load(h_adv),
        .clock_qualify_n(h_qn), .select_first_n(h_sel[0]), .select_second(h_sel[1]),
        .select_third_n(h_sel[2]), .output_en_n(oen), .burst_order_strap(strap),
        .data_lanes_in(h_wd[31:0]), .data_lanes_out(dout), .data_lanes_oe(doe),
        .parity_lanes_in(h_wd[35:32]), .parity_lanes_out(pout), .parity_lanes_oe(poe));
    task automatic op(input logic a, w, input logic [2:0] s, input logic [3:0] l,
                      input logic [AW-1:0] ad, input logic [35:0] d, input logic v, st);
        @(posedge clk);
        rq_adv <= a;
        rq_we_n <= w;
        rq_sel <= s;
        rq_ln <= l;
        rq_adr <= ad;
        rq_wd <= d;
        rq_wv <= v;
        rq_stall <= st;
    endtask
    task automatic chk(input logic [43:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [AW-1:0] ad, input logic [35:0] e);
        op(1'b0, 1'b1, 3'h7, 4'hF, ad, '0, 1'b0, 1'b0);
        op(1'b0, 1'b1, 3'h7, 4'hF, '0, '0, 1'b0, 1'b0);
        @(posedge clk);
        #1 chk({doe, poe, pout, dout}, {8'hFF, e});
    endtask
    task automatic wr(input logic [AW-1:0] ad, input logic [35:0] d, input logic [3:0] l);
        op(1'b0, 1'b0, 3'h7, l, ad, d, 1'b1, 1'b0);
    endtask
    task automatic t_lanes();
        wr(6'h00, 36'h0_0000_0000, 4'h0);
        wr(6'h08, 36'hF_1234_5678, 4'h0);
        rd(6'h08, 36'hF_1234_5678);
        wr(6'h08, 36'h0_9ABC_DEF0, 4'hA);
        rd(6'h08, 36'hA_12BC_56F0);
        op(1'b0, 1'b1, 3'h7, 4'h0, 6'h08, 36'h0, 1'b1, 1'b0);
        rd(6'h08, 36'hA_12BC_56F0);
        $display("test lanes done");
    endtask
    task automatic t_burst();
        op(1'b0, 1'b0, 3'h7, 4'h0, 6'h11, 36'h1_0000_0000, 1'b1, 1'b0);
        for (int k = 1; k < 4; k++) begin
            op(1'b1, 1'b0, 3'h7, 4'h0, 6'h00, 36'h1_0000_0000 + 36'(k), 1'b1, 1'b0);
        end
        for (int k = 0; k < 4; k++) begin
            rd({4'h4, 2'h1 ^ 2'(k)}, 36'h1_0000_0000 + 36'(k));
        end
        $display("test burst done");
    endtask
    // second reset with the strap low: linear order from base 1 differs from interleaved
    task automatic t_linear();
        @(posedge clk);
        sys_rst <= 1'b1;
        strap   <= 1'b0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk({doe, poe, pout, dout}, 44'h000_0000_0000);
        op(1'b0, 1'b0, 3'h7, 4'h0, 6'h2D, 36'h5_0000_0000, 1'b1, 1'b0);
        for (int k = 1; k < 4; k++) begin
            op(1'b1, 1'b0, 3'h7, 4'h0, 6'h00, 36'h5_0000_0000 + 36'(k), 1'b1, 1'b0);
        end
        for (int k = 0; k < 4; k++) begin
            rd({4'hB, 2'h1 + 2'(k)}, 36'h5_0000_0000 + 36'(k));
        end
        $display("test linear done");
    endtask
    task automatic t_select();
        wr(6'h14, 36'h2_2222_2222, 4'h0);
        for (int i = 0; i < 3; i++) begin
            op(1'b0, 1'b0, 3'h7 ^ (3'h1 << i), 4'h0, 6'h14, 36'h3_3333_3333, 1'b1,
               1'b0);
            op(1'b0, 1'b1, 3'h7, 4'hF, '0, '0, 1'b0, 1'b0);
            rd(6'h14, 36'h2_2222_2222);
        end
        $display("test select done");
    endtask
    task automatic t_stall();
        op(1'b0, 1'b1, 3'h7, 4'hF, 6'h14, '0, 1'b0, 1'b0);
        repeat (3) op(1'b0, 1'b0, 3'h7, 4'h0, 6'h20, 36'h7_7777_7777, 1'b1, 1'b1);
        op(1'b0, 1'b1, 3'h7, 4'hF, '0, '0, 1'b0, 1'b0);
        op(1'b0, 1'b1, 3'h7, 4'hF, '0, '0, 1'b0, 1'b1);
        #1 chk({doe, poe, pout, dout}, {8'hFF, 36'h2_2222_2222});
        op(1'b0, 1'b1, 3'h7, 4'hF, '0, '0, 1'b0, 1'b1);
        oen <= 1'b1;
        #1 chk({doe, poe, pout, dout}, {8'h00, 36'h2_2222_2222});
        op(1'b0, 1'b1, 3'h7, 4'hF, '0, '0, 1'b0, 1'b0);
        oen <= 1'b0;
        rd(6'h20, 36'h0_0000_0000 | 36'hA_12BC_56F0 & 36'h0);
        $display("test stall done");
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        wr(6'h20, 36'h0_0000_0000, 4'h0);
        t_lanes();
        t_burst();
        t_select();
        t_stall();
        t_linear();
        tally_and_finish();
    end
endmodule
`default_nettype wire
